/* core/cppc_top.v */
// charger power path control registers and their side effects
// assumes a register port driven by the serial interface engine,
// watchdog and register-reset pulses from their owners, and an adc
// that answers a start pulse with a done pulse and a result
`default_nettype none
`include "cppc_regs.vh"
module cppc_top #(
  parameter MS_CYCLES = `CPPC_MS_CYCLES
) (
  input  wire                     i_clk,
  input  wire                     i_nrst,
  // register port
  input  wire [7:0]               i_reg_addr,
  input  wire [7:0]               i_reg_wdata,
  input  wire                     i_reg_wr,
  input  wire                     i_reg_rd,
  output wire [7:0]               o_reg_rdata,
  // reset sources on the core clock
  input  wire                     i_wdog_expire,
  input  wire                     i_reg_reset,
  // pins from outside the clock domain
  input  wire                     i_pair1_present,
  input  wire                     i_pair2_present,
  input  wire                     i_strap_config_pin,
  input  wire                     i_vbat_above_min,
  input  wire                     i_wake_button_pin_n,
  // converter and adc handshake
  input  wire                     i_ship_mode,
  input  wire                     i_adc_done,
  input  wire [`CPPC_VLIM_W-1:0]  i_adc_result,
  output wire                     o_adc_start,
  output wire                     o_switch_halt,
  output wire                     o_vlimit_wr,
  output wire [`CPPC_VLIM_W-1:0]  o_vlimit_value,
  // control outputs
  output wire                     o_fet_pair1_drive,
  output wire                     o_fet_pair2_drive,
  output wire                     o_reverse_source_enable,
  output wire                     o_reverse_pulse_skip_off,
  output wire                     o_forward_pulse_skip_off,
  output wire                     o_precharge_linear_off,
  output wire                     o_reverse_audio_guard_off,
  output wire                     o_forward_audio_guard_off,
  output wire                     o_switching_rate_select,
  output wire                     o_indicator_pin_off,
  output wire                     o_system_short_hiccup_off,
  output wire                     o_reverse_undervolt_hiccup_off,
  output wire                     o_input_overcurrent_enable,
  output wire                     o_ship_exit
);
  // detection sequencer states
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_HALT = 2'b01;
  localparam [1:0] ST_MEAS = 2'b10;
  localparam [1:0] ST_LOAD = 2'b11;

  reg                    rst_meta_q;
  reg                    rst_q;
  wire [4:0]             pin_lvl;
  wire                   pair1_seen;
  wire                   pair2_seen;
  wire                   strap_lvl;
  wire                   vbat_ok;
  wire                   wake_high;

  reg  [7:0]             ctrl_a_q;
  reg  [7:0]             ctrl_b_q;
  reg  [7:0]             ctrl_b_d;
  reg  [2:0]             cap_cnt_q;
  reg                    cap_done_q;
  reg                    pair1_lock_q;
  reg                    pair2_lock_q;
  reg                    strap_q;
  reg  [1:0]             det_st_q;
  reg  [1:0]             det_st_d;
  reg                    adc_start_q;
  reg                    halt_q;
  reg                    vlim_wr_q;
  reg  [`CPPC_VLIM_W-1:0] vlim_q;
  reg  [7:0]             rdata_q;
  wire                   wr_a;
  wire                   wr_b;
  wire                   det_done;

  // release the asynchronous reset through two flip-flops
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta_q <= 1'b0;
      rst_q      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_q      <= rst_meta_q;
    end
  end

  // all external pins pass the three-stage synchroniser
  cppc_sync #(
    .W (5)
  ) u_sync (
    .i_clk   (i_clk),
    .i_rst_n (rst_q),
    .i_pin   ({i_wake_button_pin_n, i_vbat_above_min, i_strap_config_pin,
                i_pair2_present, i_pair1_present}),
    .o_level (pin_lvl)
  );

  assign pair1_seen = pin_lvl[0];
  assign pair2_seen = pin_lvl[1];
  assign strap_lvl  = pin_lvl[2];
  assign vbat_ok    = pin_lvl[3];
  assign wake_high  = pin_lvl[4];

  // catch straps and fet population once the synchronisers settle
  always @(posedge i_clk or negedge rst_q) begin
    if (!rst_q) begin
      cap_cnt_q    <= 3'h0;
      cap_done_q   <= 1'b0;
      pair1_lock_q <= 1'b1;
      pair2_lock_q <= 1'b1;
      strap_q      <= 1'b0;
    end else begin
      // counter runs two past the latch so the load cycle shows once
      if (cap_cnt_q != `CPPC_CAPTURE_WAIT + 3'h2) begin
        cap_cnt_q <= cap_cnt_q + 3'h1;
      end
      if (!cap_done_q && cap_cnt_q == `CPPC_CAPTURE_WAIT) begin
        cap_done_q   <= 1'b1;
        pair1_lock_q <= !pair1_seen;
        pair2_lock_q <= !pair2_seen;
        strap_q      <= strap_lvl;
      end
    end
  end

  assign wr_a = i_reg_wr && (i_reg_addr == `CPPC_ADDR_CTRL_A);
  assign wr_b = i_reg_wr && (i_reg_addr == `CPPC_ADDR_CTRL_B);

  // control a: host writes, register reset and watchdog defaults
  always @(posedge i_clk or negedge rst_q) begin
    if (!rst_q) begin
      ctrl_a_q <= `CPPC_RESET_A;
    end else if (i_reg_reset) begin
      // register reset keeps the block bit; only power-on or a host write clears it
      ctrl_a_q <= {ctrl_a_q[`CPPC_A_FET_BLOCK], `CPPC_RESET_A_LOW};
    end else if (wr_a) begin
      ctrl_a_q <= i_reg_wdata;
    end else if (i_wdog_expire) begin
      ctrl_a_q[`CPPC_A_REV_EN]    <= 1'b0;
      ctrl_a_q[`CPPC_A_REV_PSKIP] <= 1'b0;
      ctrl_a_q[`CPPC_A_PRE_LIN]   <= 1'b0;
      ctrl_a_q[`CPPC_A_REV_AUDIO] <= 1'b0;
    end
  end

  // control b next value
  always @* begin
    ctrl_b_d = ctrl_b_q;
    if (i_reg_reset) begin
      // pair enables are power-on only; rate reloads from the strap
      ctrl_b_d = `CPPC_RESET_B;
      ctrl_b_d[`CPPC_B_PAIR2] = ctrl_b_q[`CPPC_B_PAIR2];
      ctrl_b_d[`CPPC_B_PAIR1] = ctrl_b_q[`CPPC_B_PAIR1];
      ctrl_b_d[`CPPC_B_RATE]  = strap_q;
    end else begin
      if (wr_b) begin
        ctrl_b_d[`CPPC_B_PAIR2]     = i_reg_wdata[`CPPC_B_PAIR2];
        ctrl_b_d[`CPPC_B_PAIR1]     = i_reg_wdata[`CPPC_B_PAIR1];
        ctrl_b_d[`CPPC_B_RATE]      = i_reg_wdata[`CPPC_B_RATE];
        ctrl_b_d[`CPPC_B_IND_OFF]   = i_reg_wdata[`CPPC_B_IND_OFF];
        ctrl_b_d[`CPPC_B_SYS_SHORT] = i_reg_wdata[`CPPC_B_SYS_SHORT];
        ctrl_b_d[`CPPC_B_REV_UVP]   = i_reg_wdata[`CPPC_B_REV_UVP];
        ctrl_b_d[`CPPC_B_OCP_EN]    = i_reg_wdata[`CPPC_B_OCP_EN];
      end else if (i_wdog_expire) begin
        ctrl_b_d[`CPPC_B_IND_OFF] = 1'b0;
      end
      // hardware clear on completion; a fresh accepted write wins
      if (det_done) begin
        ctrl_b_d[`CPPC_B_DET_FORCE] = 1'b0;
      end
      if (wr_b && i_reg_wdata[`CPPC_B_DET_FORCE] && vbat_ok) begin
        ctrl_b_d[`CPPC_B_DET_FORCE] = 1'b1;
      end
    end
    // forced or locked pair enables hold zero
    if (ctrl_a_q[`CPPC_A_FET_BLOCK] || (wr_a && i_reg_wdata[`CPPC_A_FET_BLOCK])) begin
      ctrl_b_d[`CPPC_B_PAIR2] = 1'b0;
      ctrl_b_d[`CPPC_B_PAIR1] = 1'b0;
    end
    if (pair2_lock_q) begin
      ctrl_b_d[`CPPC_B_PAIR2] = 1'b0;
    end
    if (pair1_lock_q) begin
      ctrl_b_d[`CPPC_B_PAIR1] = 1'b0;
    end
  end

  // control b storage; rate takes the strap when capture completes
  always @(posedge i_clk or negedge rst_q) begin
    if (!rst_q) begin
      ctrl_b_q <= `CPPC_RESET_B;
    end else if (!cap_done_q) begin
      ctrl_b_q <= `CPPC_RESET_B;
    end else if (cap_done_q && cap_cnt_q == `CPPC_CAPTURE_WAIT + 3'h1) begin
      ctrl_b_q <= {ctrl_b_d[7:6], strap_q, ctrl_b_d[4:0]};
    end else begin
      ctrl_b_q <= ctrl_b_d;
    end
  end

  // the force bit clears the cycle after the limit is loaded
  assign det_done = vlim_wr_q;

  // forced detection sequencer next state
  always @* begin
    det_st_d = det_st_q;
    case (det_st_q)
      ST_IDLE: begin
        if (ctrl_b_q[`CPPC_B_DET_FORCE]) begin
          det_st_d = ST_HALT;
        end
      end
      ST_HALT: begin
        det_st_d = ST_MEAS;
      end
      ST_MEAS: begin
        if (i_adc_done) begin
          det_st_d = ST_LOAD;
        end
      end
      ST_LOAD: begin
        det_st_d = ST_IDLE;
      end
      default: begin
        det_st_d = ST_IDLE;
      end
    endcase
  end

  // sequencer outputs: halt switching, start adc, load the limit
  always @(posedge i_clk or negedge rst_q) begin
    if (!rst_q) begin
      det_st_q    <= ST_IDLE;
      halt_q      <= 1'b0;
      adc_start_q <= 1'b0;
      vlim_wr_q   <= 1'b0;
      vlim_q      <= {`CPPC_VLIM_W{1'b0}};
    end else if (i_reg_reset) begin
      det_st_q    <= ST_IDLE;
      halt_q      <= 1'b0;
      adc_start_q <= 1'b0;
      vlim_wr_q   <= 1'b0;
    end else begin
      det_st_q    <= det_st_d;
      adc_start_q <= (det_st_q == ST_HALT);
      halt_q      <= (det_st_d != ST_IDLE);
      vlim_wr_q   <= (det_st_q == ST_MEAS) && i_adc_done;
      if ((det_st_q == ST_MEAS) && i_adc_done) begin
        vlim_q <= i_adc_result;
      end
    end
  end

  // registered read data; unmapped addresses read zero
  always @(posedge i_clk or negedge rst_q) begin
    if (!rst_q) begin
      rdata_q <= 8'h00;
    end else if (i_reg_rd) begin
      if (i_reg_addr == `CPPC_ADDR_CTRL_A) begin
        rdata_q <= ctrl_a_q;
      end else if (i_reg_addr == `CPPC_ADDR_CTRL_B) begin
        rdata_q <= ctrl_b_q;
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end

  // ship exit timing on the wake pin
  cppc_wake_timer #(
    .MS_CYCLES (MS_CYCLES)
  ) u_wake (
    .i_clk        (i_clk),
    .i_rst_n      (rst_q),
    .i_ship_mode  (i_ship_mode),
    .i_pin_low    (!wake_high),
    .i_hold_short (ctrl_a_q[`CPPC_A_SHIP_HOLD]),
    .o_exit       (o_ship_exit)
  );

  // outputs straight from register flops
  assign o_reg_rdata                  = rdata_q;
  assign o_adc_start                  = adc_start_q;
  assign o_switch_halt                = halt_q;
  assign o_vlimit_wr                  = vlim_wr_q;
  assign o_vlimit_value               = vlim_q;
  assign o_fet_pair1_drive            = ctrl_b_q[`CPPC_B_PAIR1];
  assign o_fet_pair2_drive            = ctrl_b_q[`CPPC_B_PAIR2];
  assign o_reverse_source_enable      = ctrl_a_q[`CPPC_A_REV_EN];
  assign o_reverse_pulse_skip_off     = ctrl_a_q[`CPPC_A_REV_PSKIP];
  assign o_forward_pulse_skip_off     = ctrl_a_q[`CPPC_A_FWD_PSKIP];
  assign o_precharge_linear_off       = ctrl_a_q[`CPPC_A_PRE_LIN];
  assign o_reverse_audio_guard_off    = ctrl_a_q[`CPPC_A_REV_AUDIO];
  assign o_forward_audio_guard_off    = ctrl_a_q[`CPPC_A_FWD_AUDIO];
  assign o_switching_rate_select      = ctrl_b_q[`CPPC_B_RATE];
  assign o_indicator_pin_off          = ctrl_b_q[`CPPC_B_IND_OFF];
  assign o_system_short_hiccup_off    = ctrl_b_q[`CPPC_B_SYS_SHORT];
  assign o_reverse_undervolt_hiccup_off = ctrl_b_q[`CPPC_B_REV_UVP];
  assign o_input_overcurrent_enable   = ctrl_b_q[`CPPC_B_OCP_EN];
endmodule
`default_nettype wire

/* core/cppc_regs.vh */
// constants for the charger power path control registers
// assumes a 100 MHz core clock and an 8-bit register port
//
// Contract
// - block bit set forces both input fet pair enables to zero
// - reverse source enable: 0 off, 1 on; cleared by watchdog or register reset
// - reverse pulse skip off bit; cleared by watchdog or register reset
// - forward pulse skip off bit; restored by register reset only
// - wake pin low hold to leave ship mode: 1 s at 0, 15 ms at 1
// - precharge linear off bit; cleared by watchdog or register reset
// - reverse audio guard off bit; cleared by watchdog or register reset
// - forward audio guard off bit; restored by register reset only
// - pair 2 drive bit; locked at zero when pair 2 absent at power-on
// - pair 1 drive bit; locked at zero when pair 1 absent at power-on
// - rate select: 0 gives 1.5 MHz, 1 gives 750 kHz; strap sets power-on value
// - indicator pin off bit; cleared by watchdog or register reset
// - system short hiccup off bit; restored by register reset only
// - reverse undervolt hiccup off bit; restored by register reset only
// - detect force bit accepted only when battery above minimum; self-clears when done
// - forced detection: halt switching, measure input, update input voltage limit
// - input overcurrent enable resets to one; restored by register reset only
// - watchdog expiry returns watchdog-resettable fields to defaults
`ifndef CPPC_REGS_VH
`define CPPC_REGS_VH

`define CPPC_ADDR_CTRL_A   8'h12
`define CPPC_ADDR_CTRL_B   8'h13
`define CPPC_RESET_A       8'h00
`define CPPC_RESET_B       8'h01
// control a reset value below the block bit
`define CPPC_RESET_A_LOW   7'h00

// control a field positions
`define CPPC_A_FET_BLOCK   7
`define CPPC_A_REV_EN      6
`define CPPC_A_REV_PSKIP   5
`define CPPC_A_FWD_PSKIP   4
`define CPPC_A_SHIP_HOLD   3
`define CPPC_A_PRE_LIN     2
`define CPPC_A_REV_AUDIO   1
`define CPPC_A_FWD_AUDIO   0

// control b field positions
`define CPPC_B_PAIR2       7
`define CPPC_B_PAIR1       6
`define CPPC_B_RATE        5
`define CPPC_B_IND_OFF     4
`define CPPC_B_SYS_SHORT   3
`define CPPC_B_REV_UVP     2
`define CPPC_B_DET_FORCE   1
`define CPPC_B_OCP_EN      0

// power-on capture waits for the pin synchronisers to settle
`define CPPC_CAPTURE_WAIT  3'h4

// ship exit hold times in milliseconds
`define CPPC_SHIP_EXIT_LONG_MS  11'h3e8
`define CPPC_SHIP_EXIT_SHORT_MS 11'h00f
// clock rate in kHz gives cycles per millisecond
`define CPPC_CLK_KHZ       100000
`define CPPC_MS_CYCLES     (`CPPC_CLK_KHZ * 1)

// input voltage limit width
`define CPPC_VLIM_W        8

`endif

/* core/cppc_sync.v */
// three-stage pin synchroniser, one lane per bit
// assumes inputs come from outside the clock domain
`default_nettype none
module cppc_sync #(
  parameter W = 1
) (
  input  wire         i_clk,
  input  wire         i_rst_n,
  input  wire [W-1:0] i_pin,
  output wire [W-1:0] o_level
);
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_lane
      reg s1_q;
      reg s2_q;
      reg s3_q;
      reg lvl_q;
      // a change counts once stages two and three agree
      always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          s1_q  <= 1'b0;
          s2_q  <= 1'b0;
          s3_q  <= 1'b0;
          lvl_q <= 1'b0;
        end else begin
          s1_q <= i_pin[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            lvl_q <= s3_q;
          end
        end
      end
      assign o_level[g] = lvl_q;
    end
  endgenerate
endmodule
`default_nettype wire

/* core/cppc_wake_timer.v */
// ship-mode exit timer on the wake button pin
// assumes a synchronised active-low pin level and a ship mode flag
`default_nettype none
`include "cppc_regs.vh"
module cppc_wake_timer #(
  parameter MS_CYCLES = `CPPC_MS_CYCLES
) (
  input  wire i_clk,
  input  wire i_rst_n,
  input  wire i_ship_mode,
  input  wire i_pin_low,
  input  wire i_hold_short,
  output wire o_exit
);
  reg  [16:0] div_q;
  reg         tick_q;
  reg  [10:0] ms_q;
  reg         fired_q;
  reg         exit_q;
  wire [10:0] hold_ms;

  // millisecond enable pulse from the core clock
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_q  <= 17'h00000;
      tick_q <= 1'b0;
    end else if (!i_pin_low) begin
      div_q  <= 17'h00000;
      tick_q <= 1'b0;
    end else if (div_q == MS_CYCLES[16:0] - 17'h00001) begin
      div_q  <= 17'h00000;
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + 17'h00001;
      tick_q <= 1'b0;
    end
  end

  // hold time chosen by the ship exit hold select bit
  assign hold_ms = i_hold_short ? `CPPC_SHIP_EXIT_SHORT_MS : `CPPC_SHIP_EXIT_LONG_MS;

  // count held-low time, fire once per press
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ms_q    <= 11'h000;
      fired_q <= 1'b0;
      exit_q  <= 1'b0;
    end else begin
      exit_q <= 1'b0;
      if (!i_pin_low || !i_ship_mode) begin
        ms_q    <= 11'h000;
        fired_q <= 1'b0;
      end else if (tick_q && !fired_q) begin
        if (ms_q + 11'h001 >= hold_ms) begin
          fired_q <= 1'b1;
          exit_q  <= 1'b1;
        end
        ms_q <= ms_q + 11'h001;
      end
    end
  end

  assign o_exit = exit_q;
endmodule
`default_nettype wire

/* bench/cppc_top_properties.sv */
// assertions on the power path control register block ports
// assumes the strobe register port and adc handshake of cppc_top
`default_nettype none
module cppc_top_properties #(
  parameter int MS_CYCLES = 100000
) (
  input wire logic       i_clk,
  input wire logic       i_nrst,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic       i_reg_wr,
  input wire logic       i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  input wire logic       i_wdog_expire,
  input wire logic       i_reg_reset,
  input wire logic       i_ship_mode,
  input wire logic       i_wake_button_pin_n,
  input wire logic       i_adc_done,
  input wire logic [7:0] i_adc_result,
  input wire logic       o_adc_start,
  input wire logic       o_switch_halt,
  input wire logic       o_vlimit_wr,
  input wire logic [7:0] o_vlimit_value,
  input wire logic       o_fet_pair1_drive,
  input wire logic       o_fet_pair2_drive,
  input wire logic       o_reverse_source_enable,
  input wire logic       o_reverse_pulse_skip_off,
  input wire logic       o_forward_pulse_skip_off,
  input wire logic       o_precharge_linear_off,
  input wire logic       o_reverse_audio_guard_off,
  input wire logic       o_forward_audio_guard_off,
  input wire logic       o_switching_rate_select,
  input wire logic       o_indicator_pin_off,
  input wire logic       o_system_short_hiccup_off,
  input wire logic       o_reverse_undervolt_hiccup_off,
  input wire logic       o_input_overcurrent_enable,
  input wire logic       o_ship_exit
);
  logic       blk_q;
  // write qualifiers and visible register images
  wire        wr_a   = i_reg_wr && !i_reg_reset && i_reg_addr == 8'h12;
  wire        wd     = i_wdog_expire && !i_reg_wr && !i_reg_reset;
  wire  [5:0] a_bits = {i_reg_wdata[6:4], i_reg_wdata[2:0]};
  wire  [5:0] a_vis  = {o_reverse_source_enable, o_reverse_pulse_skip_off, o_forward_pulse_skip_off,
                        o_precharge_linear_off, o_reverse_audio_guard_off, o_forward_audio_guard_off};
  wire  [6:0] a_all  = {blk_q, a_vis};
  wire  [6:0] b_vis  = {o_fet_pair2_drive, o_fet_pair1_drive, o_switching_rate_select, o_indicator_pin_off,
                        o_system_short_hiccup_off, o_reverse_undervolt_hiccup_off, o_input_overcurrent_enable};
  // shadow of the block bit, cleared by power-on or a control a write of zero
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      blk_q <= 1'b0;
    end else if (wr_a) begin
      blk_q <= i_reg_wdata[7];
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // detection steps
  sequence s_halt_rise;
    $rose(o_switch_halt);
  endsequence
  sequence s_meas_done;
    o_switch_halt && !o_adc_start && i_adc_done;
  endsequence
  AST_BLOCK_PAIRS: assert property (blk_q |-> !o_fet_pair1_drive && !o_fet_pair2_drive)
    else $error("pair drive on while blocked");
  AST_WRITE_A: assert property (wr_a |=> a_vis == $past(a_bits))
    else $error("control a outputs differ from write");
  AST_WDOG_CLEAR: assert property (wd |=> (a_vis & 6'h36) == 6'h00 && !o_indicator_pin_off)
    else $error("watchdog left a field set");
  AST_WDOG_KEEP: assert property (wd |=> $stable({a_vis[3], a_vis[0], b_vis[2:0]}))
    else $error("watchdog touched a kept field");
  AST_REG_RESET: assert property (i_reg_reset |=> a_vis == 6'h00 && b_vis[3:0] == 4'h1)
    else $error("register reset values wrong");
  AST_READ_A: assert property (i_reg_rd && i_reg_addr == 8'h12 |=>
    {o_reg_rdata[7:4], o_reg_rdata[2:0]} == $past(a_all))
    else $error("control a read wrong");
  AST_READ_B: assert property (i_reg_rd && i_reg_addr == 8'h13 |=>
    {o_reg_rdata[7:2], o_reg_rdata[0]} == $past(b_vis))
    else $error("control b read wrong");
  AST_UNMAPPED: assert property (i_reg_rd && i_reg_addr != 8'h12 && i_reg_addr != 8'h13 |=> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_DET_START: assert property (s_halt_rise |=> o_adc_start ##1 !o_adc_start)
    else $error("adc start not after halt");
  AST_DET_RESULT: assert property (s_meas_done |=> o_vlimit_wr && o_vlimit_value == $past(i_adc_result))
    else $error("limit update wrong");
  AST_DET_END: assert property (o_vlimit_wr |=> !o_switch_halt)
    else $error("halt held after update");
  AST_SHIP_EXIT: assert property (o_ship_exit |->
    ($past(i_wake_button_pin_n, 8) == 1'b0 && $past(i_ship_mode, 8)) ##1 !o_ship_exit)
    else $error("ship exit without held pin");
endmodule
bind cppc_top cppc_top_properties #(.MS_CYCLES(MS_CYCLES)) chk_u (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
  .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_wdog_expire(i_wdog_expire),
  .i_reg_reset(i_reg_reset), .i_ship_mode(i_ship_mode), .i_wake_button_pin_n(i_wake_button_pin_n),
  .i_adc_done(i_adc_done), .i_adc_result(i_adc_result), .o_adc_start(o_adc_start),
  .o_switch_halt(o_switch_halt), .o_vlimit_wr(o_vlimit_wr), .o_vlimit_value(o_vlimit_value),
  .o_fet_pair1_drive(o_fet_pair1_drive), .o_fet_pair2_drive(o_fet_pair2_drive),
  .o_reverse_source_enable(o_reverse_source_enable), .o_reverse_pulse_skip_off(o_reverse_pulse_skip_off),
  .o_forward_pulse_skip_off(o_forward_pulse_skip_off), .o_precharge_linear_off(o_precharge_linear_off),
  .o_reverse_audio_guard_off(o_reverse_audio_guard_off), .o_forward_audio_guard_off(o_forward_audio_guard_off),
  .o_switching_rate_select(o_switching_rate_select), .o_indicator_pin_off(o_indicator_pin_off),
  .o_system_short_hiccup_off(o_system_short_hiccup_off),
  .o_reverse_undervolt_hiccup_off(o_reverse_undervolt_hiccup_off),
  .o_input_overcurrent_enable(o_input_overcurrent_enable), .o_ship_exit(o_ship_exit)
);
`default_nettype wire

/* bench/cppc_adc_model.sv */
// behavioural adc on the far side of the detection handshake
// assumes a one-cycle start pulse; answers after 1 or 20 cycles
`default_nettype none
module cppc_adc_model (
  input  wire logic       i_clk,
  input  wire logic       i_start,
  input  wire logic       i_slow,
  input  wire logic [7:0] i_value,
  output var  logic       o_done,
  output var  logic [7:0] o_result
);
  timeunit 1ns;
  timeprecision 1ps;
  int         wait_n = 0;
  logic [7:0] junk   = 8'h5a;
  initial o_done = 1'b0;
  // measure the unloaded input, result line churns when not valid
  always @(posedge i_clk) begin
    junk     <= junk + 8'h35;
    o_done   <= 1'b0;
    o_result <= junk;
    if (i_start) begin
      wait_n <= i_slow ? 20 : 1;
    end else if (wait_n == 1) begin
      o_done   <= 1'b1;
      o_result <= i_value;
      wait_n   <= 0;
    end else if (wait_n > 1) begin
      wait_n <= wait_n - 1;
    end
  end
endmodule
`default_nettype wire

/* bench/charger_power_path_controls_bench.sv */
// self-checking bench for the power path control registers
// assumes cppc_top with a short millisecond count and the adc model
`default_nettype none
module charger_power_path_controls_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MS = 10;
  logic       clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, wdog = 1'b0, rrst = 1'b0;
  logic       p1 = 1'b1, p2 = 1'b1, strap = 1'b0, vbat = 1'b0, wake_n = 1'b1, ship = 1'b0, slow = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, adc_val = 8'h00, rdata, vlim, adc_res;
  logic       adc_start, adc_done, vl_wr, ship_exit, pair1, pair2, ocp;
  int         n_errors = 0;
  int         num_checks = 0;
  int         cyc;
  initial forever #5 clk = ~clk;
  cppc_top #(.MS_CYCLES(MS)) dut_u (
    .i_clk(clk), .i_nrst(nrst), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
    .o_reg_rdata(rdata), .i_wdog_expire(wdog), .i_reg_reset(rrst), .i_pair1_present(p1),
    .i_pair2_present(p2), .i_strap_config_pin(strap), .i_vbat_above_min(vbat),
    .i_wake_button_pin_n(wake_n), .i_ship_mode(ship), .i_adc_done(adc_done), .i_adc_result(adc_res),
    .o_adc_start(adc_start), .o_switch_halt(), .o_vlimit_wr(vl_wr), .o_vlimit_value(vlim),
    .o_fet_pair1_drive(pair1), .o_fet_pair2_drive(pair2), .o_reverse_source_enable(),
    .o_reverse_pulse_skip_off(), .o_forward_pulse_skip_off(), .o_precharge_linear_off(),
    .o_reverse_audio_guard_off(), .o_forward_audio_guard_off(), .o_switching_rate_select(),
    .o_indicator_pin_off(), .o_system_short_hiccup_off(), .o_reverse_undervolt_hiccup_off(),
    .o_input_overcurrent_enable(ocp), .o_ship_exit(ship_exit)
  );
  cppc_adc_model adc_u (
    .i_clk(clk), .i_start(adc_start), .i_slow(slow), .i_value(adc_val), .o_done(adc_done), .o_result(adc_res)
  );
  // compare and count
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one strobe cycle on the register port
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    check("register read", rdata, exp);
  endtask
  task automatic power_up;
    @(posedge clk);
    nrst <= 1'b0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (12) @(posedge clk);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    power_up();
    rd_chk(8'h12, 8'h00);
    rd_chk(8'h13, 8'h01);
    check("overcurrent enable", {7'h00, ocp}, 8'h01);
    wr_reg(8'h12, 8'h7f);
    rd_chk(8'h12, 8'h7f);
    wr_reg(8'h13, 8'hff);
    rd_chk(8'h13, 8'hfd);
    @(posedge clk);
    wdog <= 1'b1;
    @(posedge clk);
    wdog <= 1'b0;
    rd_chk(8'h12, 8'h19);
    rd_chk(8'h13, 8'hed);
    wr_reg(8'h12, 8'h80);
    rd_chk(8'h13, 8'h2d);
    wr_reg(8'h13, 8'hed);
    rd_chk(8'h13, 8'h2d);
    @(posedge clk);
    rrst <= 1'b1;
    @(posedge clk);
    rrst <= 1'b0;
    rd_chk(8'h12, 8'h80);
    rd_chk(8'h13, 8'h01);
    wr_reg(8'h11, 8'hff);
    rd_chk(8'h12, 8'h80);
    rd_chk(8'h14, 8'h00);
    // forced detection, prompt then slow adc
    @(posedge clk);
    vbat <= 1'b1;
    repeat (10) @(posedge clk);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      slow    <= i[0];
      adc_val <= i[0] ? 8'hc5 : 8'h3a;
      wr_reg(8'h13, 8'h03);
      cyc = 0;
      while (vl_wr !== 1'b1 && cyc < 100) begin
        @(posedge clk);
        #1;
        cyc++;
      end
      check("limit value", vlim, i[0] ? 8'hc5 : 8'h3a);
      rd_chk(8'h13, 8'h01);
    end
    // short ship exit hold
    @(posedge clk);
    ship <= 1'b1;
    wr_reg(8'h12, 8'h88);
    @(posedge clk);
    wake_n <= 1'b0;
    cyc = 0;
    while (ship_exit !== 1'b1 && cyc < 400) begin
      @(posedge clk);
      #1;
      cyc++;
    end
    check("ship exit window", {7'h00, cyc >= 15 * MS && cyc <= 15 * MS + 15}, 8'h01);
    // second power-on with pair 2 absent and strap high
    @(posedge clk);
    wake_n <= 1'b1;
    ship   <= 1'b0;
    p2     <= 1'b0;
    strap  <= 1'b1;
    power_up();
    rd_chk(8'h13, 8'h21);
    wr_reg(8'h13, 8'hc1);
    rd_chk(8'h13, 8'h41);
    check("pair drives", {6'h00, pair2, pair1}, 8'h01);
    results();
  end
  // hang guard
  initial begin
    #100us;
    n_errors++;
    results();
  end
endmodule
`default_nettype wire
